// ==== dual_pwm_output_unit.sv ====
`timescale 1ns/10ps
module dual_pwm_output_unit
    import pwm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [COUNT_W-1:0] timer_a_count,
    input wire logic [SUB_W-1:0] timer_a_sub,
    input wire logic timer_a_restart,
    input wire logic [COUNT_W-1:0] timer_b_count,
    input wire logic [SUB_W-1:0] timer_b_sub,
    input wire logic timer_b_restart,
    output logic [CHANNELS-1:0] main_pin_out,
    output logic [CHANNELS-1:0] main_pin_oe,
    output logic [CHANNELS*EXTRA_PINS-1:0] extra_pin_out,
    output logic [CHANNELS*EXTRA_PINS-1:0] extra_pin_oe
);

    // ****************************************
    // register state
    // ****************************************
    typedef struct packed
    {
        logic [CHANNELS-1:0] modulator_on;
        logic [CHANNELS-1:0] main_pin_drive_enable;
        logic [CHANNELS-1:0] output_invert;
        logic [CHANNELS*EXTRA_PINS-1:0] extra_pin_drive_enables;
        logic first_channel_timer_choice;
        logic second_channel_timer_choice;
        logic ready;
        logic err;
        logic [31:0] rdata;
    } cfg_state_t;

    // duty keeps its value across resets, so it has no reset branch
    typedef struct packed
    {
        logic [CHANNELS*8-1:0] upper;
        logic [CHANNELS*2-1:0] lower;
    } duty_state_t;

    cfg_state_t cfg_reg;
    cfg_state_t cfg_next;
    duty_state_t duty_reg;
    duty_state_t duty_next;
    logic [CHANNELS-1:0] level_view;
    logic [CHANNELS-1:0] active;

    logic setup;
    logic commit;
    logic [7:0] field;
    logic [3:0] chan_sel;
    logic ch;
    logic tsel_hit;
    logic mapped;

    assign setup = psel && !penable;
    assign commit = psel && penable && cfg_reg.ready;
    assign field = paddr & CH_FIELD_MASK;
    assign chan_sel = paddr[7:4];
    assign ch = chan_sel[0];
    assign tsel_hit = (paddr == ADDR_TSEL);
    assign mapped = tsel_hit || ((chan_sel < 4'(CHANNELS)) && (field[1:0] == 2'b00));

    // ****************************************
    // apb slave, one wait-free access phase
    // ****************************************
    always_comb
    begin
        cfg_next = cfg_reg;
        duty_next = duty_reg;
        cfg_next.ready = setup;
        cfg_next.err = setup && !mapped;
        cfg_next.rdata = RDATA_ZERO;
        if (setup && !pwrite && mapped)
        begin
            if (tsel_hit)
            begin
                cfg_next.rdata[TSEL_FIRST_BIT] = cfg_reg.first_channel_timer_choice;
                cfg_next.rdata[TSEL_SECOND_BIT] = cfg_reg.second_channel_timer_choice;
            end
            else
            begin
                case (field)
                    ADDR_CTRL:
                    begin
                        cfg_next.rdata[CTRL_ON_BIT] = cfg_reg.modulator_on[ch];
                        cfg_next.rdata[CTRL_MAIN_OE_BIT] = cfg_reg.main_pin_drive_enable[ch];
                        cfg_next.rdata[CTRL_LEVEL_BIT] = level_view[ch];
                        cfg_next.rdata[CTRL_INVERT_BIT] = cfg_reg.output_invert[ch];
                    end
                    ADDR_DUTY_UP:
                    begin
                        cfg_next.rdata[7:0] = duty_reg.upper[ch*8 +: 8];
                    end
                    ADDR_DUTY_LO:
                    begin
                        cfg_next.rdata[DUTY_LO_SHIFT +: 2] = duty_reg.lower[ch*2 +: 2];
                    end
                    ADDR_EXTRA:
                    begin
                        cfg_next.rdata[EXTRA_PINS-1:0] =
                            cfg_reg.extra_pin_drive_enables[ch*EXTRA_PINS +: EXTRA_PINS];
                    end
                    default:
                    begin
                        cfg_next.rdata = RDATA_ZERO;
                    end
                endcase
            end
        end
        if (commit && pwrite && mapped)
        begin
            if (tsel_hit)
            begin
                cfg_next.second_channel_timer_choice = pwdata[TSEL_SECOND_BIT];
                cfg_next.first_channel_timer_choice = pwdata[TSEL_FIRST_BIT];
            end
            else
            begin
                case (field)
                    ADDR_CTRL:
                    begin
                        // level bit is read-only, so it is not stored
                        cfg_next.modulator_on[ch] = pwdata[CTRL_ON_BIT];
                        cfg_next.main_pin_drive_enable[ch] = pwdata[CTRL_MAIN_OE_BIT];
                        cfg_next.output_invert[ch] = pwdata[CTRL_INVERT_BIT];
                    end
                    ADDR_DUTY_UP:
                    begin
                        duty_next.upper[ch*8 +: 8] = pwdata[7:0];
                    end
                    ADDR_DUTY_LO:
                    begin
                        duty_next.lower[ch*2 +: 2] = pwdata[DUTY_LO_SHIFT +: 2];
                    end
                    ADDR_EXTRA:
                    begin
                        cfg_next.extra_pin_drive_enables[ch*EXTRA_PINS +: EXTRA_PINS] =
                            pwdata[EXTRA_PINS-1:0];
                    end
                    default:
                    begin
                        cfg_next.err = 1'b0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_reg <= '0;
            cfg_reg.first_channel_timer_choice <= TSEL_RESET[TSEL_FIRST_BIT];
            cfg_reg.second_channel_timer_choice <= TSEL_RESET[TSEL_SECOND_BIT];
            cfg_reg.modulator_on <= {CHANNELS{CTRL_RESET[CTRL_ON_BIT]}};
            cfg_reg.extra_pin_drive_enables <= {CHANNELS{EXTRA_RESET}};
        end
        else
        begin
            cfg_reg <= cfg_next;
        end
    end

    always_ff @(posedge pclk)
    begin
        duty_reg <= duty_next;
    end

    assign prdata = cfg_reg.rdata;
    assign pready = cfg_reg.ready;
    assign pslverr = cfg_reg.err;

    // ****************************************
    // per-channel modulator and pins
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi++)
        begin : g_chan
            pwm_timebase_if tb ();
            logic use_b;

            assign use_b = (gi == 0) ? cfg_reg.first_channel_timer_choice
                                     : cfg_reg.second_channel_timer_choice;
            assign tb.count = use_b ? timer_b_count : timer_a_count;
            assign tb.sub = use_b ? timer_b_sub : timer_a_sub;
            assign tb.restart = use_b ? timer_b_restart : timer_a_restart;
            assign tb.duty = {duty_reg.upper[gi*8 +: 8], duty_reg.lower[gi*2 +: 2]};
            assign tb.enable = cfg_reg.modulator_on[gi];

            pwm_modulator u_mod
            (
                .pclk(pclk),
                .presetn(presetn),
                .tb(tb.take),
                .active(active[gi])
            );

            pwm_pin_stage u_pins
            (
                .pclk(pclk),
                .presetn(presetn),
                .active(active[gi]),
                .invert(cfg_reg.output_invert[gi]),
                .main_pin_drive_enable(cfg_reg.main_pin_drive_enable[gi]),
                .extra_pin_drive_enables(
                    cfg_reg.extra_pin_drive_enables[gi*EXTRA_PINS +: EXTRA_PINS]),
                .level(level_view[gi]),
                .main_pin_oe(main_pin_oe[gi]),
                .extra_pin_out(extra_pin_out[gi*EXTRA_PINS +: EXTRA_PINS]),
                .extra_pin_oe(extra_pin_oe[gi*EXTRA_PINS +: EXTRA_PINS])
            );
        end
    endgenerate

    // main pin carries the same registered level that software reads
    assign main_pin_out = level_view;

endmodule : dual_pwm_output_unit

// ==== pwm_pkg.sv ====
package pwm_pkg;

    // ****************************************
    // sizes
    // ****************************************
    localparam int CHANNELS = 2;
    localparam int EXTRA_PINS = 4;
    localparam int DUTY_W = 10;
    localparam int COUNT_W = 8;
    localparam int SUB_W = 2;

    // ****************************************
    // apb byte addresses
    // ****************************************
    localparam logic [7:0] ADDR_CH_STRIDE = 8'h10;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_DUTY_UP = 8'h04;
    localparam logic [7:0] ADDR_DUTY_LO = 8'h08;
    localparam logic [7:0] ADDR_EXTRA = 8'h0C;
    localparam logic [7:0] ADDR_TSEL = 8'h20;
    localparam logic [7:0] CH_FIELD_MASK = 8'h0F;

    // ****************************************
    // field positions
    // ****************************************
    localparam int CTRL_ON_BIT = 7;
    localparam int CTRL_MAIN_OE_BIT = 6;
    localparam int CTRL_LEVEL_BIT = 5;
    localparam int CTRL_INVERT_BIT = 4;
    localparam int TSEL_FIRST_BIT = 0;
    localparam int TSEL_SECOND_BIT = 2;
    localparam int DUTY_LO_SHIFT = 6;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] TSEL_RESET = 8'h00;
    localparam logic [3:0] EXTRA_RESET = 4'h0;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
    localparam logic [DUTY_W-1:0] DUTY_ZERO = 10'h000;

endpackage : pwm_pkg

// ==== pwm_timebase_if.sv ====
`timescale 1ns/10ps
interface pwm_timebase_if;
    import pwm_pkg::*;
    logic [COUNT_W-1:0] count;
    logic [SUB_W-1:0] sub;
    logic restart;
    logic [DUTY_W-1:0] duty;
    logic enable;

    modport drive
    (
        output count,
        output sub,
        output restart,
        output duty,
        output enable
    );
    modport take
    (
        input count,
        input sub,
        input restart,
        input duty,
        input enable
    );
endinterface : pwm_timebase_if

// ==== pwm_modulator.sv ====
`timescale 1ns/10ps
module pwm_modulator
    import pwm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    pwm_timebase_if.take tb,
    output logic active
);

    typedef struct packed
    {
        logic [DUTY_W-1:0] compare;
        logic raw;
    } mod_state_t;

    mod_state_t state_reg;
    mod_state_t state_next;

    always_comb
    begin
        state_next = state_reg;
        if (tb.restart)
        begin
            state_next.compare = tb.duty;
            state_next.raw = (tb.duty != DUTY_ZERO);
        end
        // a duty past the period never matches
        else if ({tb.count, tb.sub} == state_reg.compare)
        begin
            state_next.raw = 1'b0;
        end
        if (!tb.enable)
        begin
            state_next.raw = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign active = state_reg.raw;

endmodule : pwm_modulator

// ==== pwm_pin_stage.sv ====
`timescale 1ns/10ps
module pwm_pin_stage
    import pwm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic active,
    input wire logic invert,
    input wire logic main_pin_drive_enable,
    input wire logic [EXTRA_PINS-1:0] extra_pin_drive_enables,
    output logic level,
    output logic main_pin_oe,
    output logic [EXTRA_PINS-1:0] extra_pin_out,
    output logic [EXTRA_PINS-1:0] extra_pin_oe
);

    typedef struct packed
    {
        logic level;
        logic main_oe;
        logic [EXTRA_PINS-1:0] extra_out;
        logic [EXTRA_PINS-1:0] extra_oe;
    } pin_state_t;

    pin_state_t state_reg;
    pin_state_t state_next;

    always_comb
    begin
        state_next = state_reg;
        state_next.level = active ^ invert;
        state_next.main_oe = main_pin_drive_enable;
        state_next.extra_oe = extra_pin_drive_enables;
        state_next.extra_out = {EXTRA_PINS{active ^ invert}};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign level = state_reg.level;
    assign main_pin_oe = state_reg.main_oe;
    assign extra_pin_out = state_reg.extra_out;
    assign extra_pin_oe = state_reg.extra_oe;

endmodule : pwm_pin_stage

// ==== pwm_unit_chk.sv ====
`timescale 1ns/10ps
module pwm_unit_chk
    import pwm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [CHANNELS-1:0] main_pin_oe,
    input wire logic [CHANNELS*EXTRA_PINS-1:0] extra_pin_oe
);
    // ****************
    // shadows of written pin enables
    // ****************
    logic wr_hit;
    logic rd_hit;
    logic in_ch;
    logic [1:0] oe_reg;
    logic [7:0] xoe_reg;
    assign wr_hit = psel && penable && pready && pwrite;
    assign rd_hit = pready && !pwrite;
    assign in_ch = paddr < ADDR_TSEL;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            oe_reg <= 2'h0;
            xoe_reg <= 8'h00;
        end
        else if (wr_hit && in_ch && paddr[3:0] == ADDR_CTRL[3:0])
            oe_reg[paddr[4]] <= pwdata[CTRL_MAIN_OE_BIT];
        else if (wr_hit && in_ch && paddr[3:0] == ADDR_EXTRA[3:0])
            xoe_reg[{paddr[4], 2'b00} +: 4] <= pwdata[3:0];
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ****************
    // assertions
    // ****************
    ready_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("ready missing in access cycle");
    ready_cause_a: assert property (pready |-> psel && penable && $past(psel && !penable))
        else $error("ready without setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    rdata_idle_a: assert property (!pready |-> prdata == RDATA_ZERO)
        else $error("read data outside access");
    unmapped_err_a: assert property (psel && !penable && paddr > ADDR_TSEL
        |=> pslverr && (pwrite || prdata == RDATA_ZERO))
        else $error("unmapped access not refused");
    ctrl_rsvd_a: assert property (rd_hit && in_ch && paddr[3:0] == 4'h0 |-> prdata[3:0] == 4'h0)
        else $error("control low bits not zero");
    tsel_rsvd_a: assert property (rd_hit && paddr == ADDR_TSEL |-> (prdata[7:0] & 8'hFA) == 8'h00)
        else $error("select unused bits not zero");
    extra_rsvd_a: assert property (rd_hit && in_ch && paddr[3:0] == 4'hC |-> prdata[7:4] == 4'h0)
        else $error("extra enable upper bits not zero");
    duty_lo_rsvd_a: assert property (rd_hit && in_ch && paddr[3:0] == 4'h8 |-> prdata[5:0] == 6'h00)
        else $error("duty lower unused bits not zero");
    main_oe_a: assert property (main_pin_oe == $past(oe_reg))
        else $error("main pin enable differs from written value");
    extra_oe_a: assert property (extra_pin_oe == $past(xoe_reg))
        else $error("extra pin enables differ from written value");
    cover property (wr_hit && paddr == ADDR_TSEL);
    cover property (pready && pslverr);
    cover property (extra_pin_oe != 8'h00 && main_pin_oe == 2'h0);
endmodule : pwm_unit_chk

bind dual_pwm_output_unit pwm_unit_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .main_pin_oe(main_pin_oe), .extra_pin_oe(extra_pin_oe));

// ==== pwm_pin_load.sv ====
`timescale 1ns/10ps
module pwm_pin_load
    import pwm_pkg::*;
(
    input wire logic [CHANNELS-1:0] main_pin_out,
    input wire logic [CHANNELS-1:0] main_pin_oe,
    input wire logic [CHANNELS*EXTRA_PINS-1:0] extra_pin_out,
    input wire logic [CHANNELS*EXTRA_PINS-1:0] extra_pin_oe,
    output logic [CHANNELS-1:0] main_pin_level,
    output logic [CHANNELS*EXTRA_PINS-1:0] extra_pin_level
);
    // loads carry pull-downs, so an undriven pin reads low, never the last value
    assign main_pin_level = main_pin_out & main_pin_oe;
    assign extra_pin_level = extra_pin_out & extra_pin_oe;
endmodule : pwm_pin_load

// ==== tb_top.sv ====
`timescale 1ns/10ps
module tb_top
    import pwm_pkg::*;
;
    localparam int PER_A = 3;
    localparam int PER_B = 6;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, run, chk_en;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr;
    logic [1:0] main_pin_out, main_pin_oe, main_level, m_act, m_lvl, m_oe;
    // level as the slave saw it at the setup edge of the last transfer
    logic [1:0] rd_lvl;
    logic [7:0] extra_pin_out, extra_pin_oe, extra_level, m_xoe;
    int fail_count, comparisons, ca, cb, m_tsel;
    int m_ctrl[2], m_dh[2], m_dl[2], m_xe[2], m_buf[2];
    logic [7:0] regs_all[9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
    always #5 pclk = ~pclk;
    dual_pwm_output_unit DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_a_count(ca[9:2]), .timer_a_sub(ca[1:0]),
        .timer_a_restart(ca == 4 * PER_A + 3), .timer_b_count(cb[9:2]), .timer_b_sub(cb[1:0]),
        .timer_b_restart(cb == 4 * PER_B + 3), .main_pin_out(main_pin_out),
        .main_pin_oe(main_pin_oe), .extra_pin_out(extra_pin_out), .extra_pin_oe(extra_pin_oe));
    pwm_pin_load loads (.main_pin_out(main_pin_out), .main_pin_oe(main_pin_oe),
        .extra_pin_out(extra_pin_out), .extra_pin_oe(extra_pin_oe),
        .main_pin_level(main_level), .extra_pin_level(extra_level));
    // ****************
    // timers and reference model
    // ****************
    always @(posedge pclk)
    begin
        if (run)
        begin
            ca <= (ca == 4 * PER_A + 3) ? 0 : ca + 1;
            cb <= (cb == 4 * PER_B + 3) ? 0 : cb + 1;
        end
    end
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            m_ctrl <= '{0, 0};
            m_xe <= '{0, 0};
            m_tsel <= 0;
            m_act <= 2'h0;
            m_lvl <= 2'h0;
            m_oe <= 2'h0;
            m_xoe <= 8'h00;
        end
        else
            for (int c = 0; c < 2; c++)
            begin
                bit rs;
                int cnt, duty;
                cnt = m_tsel[2 * c] ? cb : ca;
                rs = m_tsel[2 * c] ? (cb == 4 * PER_B + 3) : (ca == 4 * PER_A + 3);
                duty = m_dh[c] * 4 + m_dl[c];
                if (!m_ctrl[c][7])
                    m_act[c] <= 1'b0;
                else if (rs)
                    m_act[c] <= duty != 0;
                else if (cnt == m_buf[c])
                    m_act[c] <= 1'b0;
                if (rs)
                    m_buf[c] <= duty;
                m_lvl[c] <= m_act[c] ^ m_ctrl[c][4];
                m_oe[c] <= m_ctrl[c][6];
                m_xoe[c * 4 +: 4] <= 4'(m_xe[c]);
            end
    end
    // ****************
    // bus tasks and checks
    // ****************
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            $display("unexpected %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic err);
        int n;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
        @(posedge pclk);
        rd_lvl = m_lvl;
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        q = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        check("ready", 32'h1, 32'(pready));
        if (wr && a == ADDR_TSEL)
            m_tsel <= d & 32'h0000_0005;
        else if (wr && a < ADDR_TSEL)
            case (a[3:0])
                4'h0: m_ctrl[a[4]] <= d & 32'h0000_00D0;
                4'h4: m_dh[a[4]] <= d[7:0];
                4'h8: m_dl[a[4]] <= d[7:6];
                4'hC: m_xe[a[4]] <= d[3:0];
                default: ;
            endcase
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a);
        logic [31:0] q, x;
        logic e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        x = 0;
        if (a == ADDR_TSEL)
            x = m_tsel;
        else if (a < ADDR_TSEL)
            case (a[3:0])
                4'h0: x = m_ctrl[a[4]] | (32'(rd_lvl[a[4]]) << 5);
                4'h4: x = m_dh[a[4]];
                4'h8: x = m_dl[a[4]] << 6;
                default: x = m_xe[a[4]];
            endcase
        check("read data", x, q);
        check("error flag", 32'(a > ADDR_TSEL), 32'(e));
    endtask : rd_chk
    task automatic do_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
    endtask : do_reset
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done
    always @(negedge pclk)
    begin
        if (chk_en)
        begin
            check("main levels", 32'(m_lvl & m_oe), 32'(main_level));
            check("extra levels", 32'({{4{m_lvl[1]}}, {4{m_lvl[0]}}} & m_xoe), 32'(extra_level));
            check("pin enables", 32'({m_oe, m_xoe}), 32'({main_pin_oe, extra_pin_oe}));
        end
    end
    // ****************
    // scenarios
    // ****************
    initial
    begin
        logic [31:0] d;
        {presetn, psel, penable, pwrite, paddr, pwdata, run, chk_en} = '0;
        {fail_count, comparisons, ca, cb} = '0;
        void'($urandom(32'h3b47));
        do_reset();
        foreach (regs_all[i])
            if (regs_all[i][3:2] inside {2'b00, 2'b11})
                rd_chk(regs_all[i]);
        rd_chk(8'h24);
        rd_chk(8'h3C);
        for (int c = 0; c < 2; c++)
        begin
            wr(8'(c * 16), 32'h0000_0000);
            wr(8'(c * 16 + 4), 32'h0000_0000);
            wr(8'(c * 16 + 8), 32'h0000_0000);
        end
        wr(ADDR_TSEL, 32'h0000_0004);
        run <= 1'b1;
        repeat (4 * PER_B + 4) @(posedge pclk);
        foreach (regs_all[i])
        begin
            d = $urandom;
            if (regs_all[i][3:0] == 4'h0 && regs_all[i] < ADDR_TSEL)
                d[7] = 1'b0;
            wr(regs_all[i], d);
        end
        repeat (4) @(posedge pclk);
        foreach (regs_all[i])
            rd_chk(regs_all[i]);
        repeat (20)
        begin
            chk_en <= 1'b0;
            wr(ADDR_TSEL, $urandom);
            for (int c = 0; c < 2; c++)
            begin
                wr(8'(c * 16 + 12), $urandom);
                wr(8'(c * 16 + 4), $urandom % 10);
                wr(8'(c * 16 + 8), $urandom);
                wr(8'(c * 16), $urandom | ($urandom & 32'h0000_0080));
            end
            repeat (3) @(posedge pclk);
            chk_en <= 1'b1;
            repeat (30) @(posedge pclk);
            wr(8'h04, $urandom % 10);
            wr(8'h18, $urandom);
            repeat (60) @(posedge pclk);
        end
        wr(8'h1C, 32'h0000_0000);
        wr(8'h10, 32'h0000_0080);
        rd_chk(8'h1C);
        for (int k = 0; k < 2; k++)
        begin
            wr(8'h04, k ? 32'h0000_00FF : 32'h0000_0000);
            wr(8'h08, k ? 32'h0000_00C0 : 32'h0000_0000);
            wr(8'h00, 32'h0000_00C0 | ($urandom & 32'h0000_0010));
            repeat (70) @(posedge pclk);
            rd_chk(8'h00);
        end
        chk_en <= 1'b0;
        do_reset();
        foreach (regs_all[i])
            rd_chk(regs_all[i]);
        test_done();
    end
    initial
    begin
        #500_000;
        fail_count++;
        test_done();
    end
endmodule : tb_top
